// ---- logic/wtfr_pkg.sv ----
// Purpose: shared constants and types of the watchdog with feed sequence
// Assumes: classic Wishbone slave, 32-bit data, byte addresses
// Notes:   all state of the top module lives in one packed struct
package wtfr_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register map
   localparam logic [31:0] ADDR_MODE    = 32'hE000_0000;
   localparam logic [31:0] ADDR_RELOAD  = 32'hE000_0004;
   localparam logic [31:0] ADDR_FEED    = 32'hE000_0008;
   localparam logic [31:0] ADDR_COUNT   = 32'hE000_000C;

   // mode register fields
   localparam int          MODE_EN_BIT   = 0;
   localparam int          MODE_RST_BIT  = 1;
   localparam int          MODE_TOF_BIT  = 2;
   localparam int          MODE_IRQ_BIT  = 3;

   // reset values and limits
   localparam logic [31:0] RELOAD_MIN    = 32'h0000_00FF;
   localparam logic [31:0] RELOAD_RST    = 32'h0000_00FF;
   localparam logic [31:0] COUNT_RST     = 32'h0000_00FF;
   localparam logic [31:0] COUNT_ZERO    = 32'h0000_0000;
   localparam logic [31:0] COUNT_ONE     = 32'h0000_0001;

   // feed values
   localparam logic [7:0]  FEED_FIRST    = 8'hAA;
   localparam logic [7:0]  FEED_SECOND   = 8'h55;

   // fixed divide-by-4 prescaler
   localparam int          PRESCALE_DIV  = 4;
   localparam logic [1:0]  PRESCALE_LAST = 2'(PRESCALE_DIV - 1);
   localparam logic [1:0]  PRESCALE_ONE  = 2'h1;
   localparam logic [1:0]  PRESCALE_RST  = 2'h0;

   ////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [0:0] {
      FEED_IDLE,
      FEED_GOT_FIRST
   } wtfr_feed_type;

   typedef struct packed {
      logic          ack;
      logic [31:0]   rdata;
      logic          dog_enable;
      logic          chip_reset_enable;
      logic          timeout_flag;
      logic          timeout_irq_flag;
      logic          running;
      logic          err_pend;
      logic          chip_reset;
      logic [1:0]    prescale;
      logic [31:0]   reload_constant;
      logic [31:0]   current_count;
      wtfr_feed_type feed;
   } wtfr_state_type;

endpackage : wtfr_pkg

// ---- logic/wtfr_top.sv ----
// Purpose: watchdog with prescaled 32-bit down-counter and feed sequence
// Assumes: classic Wishbone slave on clk_i, inputs synchronous to clk_i
// Notes:   chip_reset_o is a one-cycle request to the system reset logic
//
// Operation
// R1: counter decrements once per four clocks
// R2: reload writes below 0xFF store 0xFF
// R3: feed 0xAA then 0x55 reloads counter
// R4: enable alone waits for first valid feed
// R5: bad feeds ignored before first valid feed
// R6: bad access after 0xAA fires action while running
// R7: bad-access action appears two clocks later
// R8: enable low keeps watchdog inactive
// R9: interrupt mode sets flag, raises request
// R10: reset mode resets chip, clears interrupt flag
// R11: enable bits set-only, cleared by resets; the code also clears them on an interrupt-mode time-out
// R12: time-out flag survives watchdog reset
// R13: interrupt flag read-only, request held until reset
// R14: mode bits en, reset, time-out, interrupt
// R15: 32-bit reload, reset 0xFF, copied on feed
// R16: count register read-only, reset 0xFF
// R17: watchdog reset restarts program like external
// R18: software masks interrupts during feed pair
// R19: feed register write-only, 8-bit pair
// R20: underflow from zero gives one action pulse
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps

module wtfr_top
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [31:0] adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   output logic             irq_o,
   output logic             chip_reset_o
);

   ////////////////////////////////////////////////////////////////////////
   // state
   wtfr_pkg::wtfr_state_type s_q;
   wtfr_pkg::wtfr_state_type s_d;

   logic        req;
   logic        hit_mode;
   logic        hit_reload;
   logic        hit_feed;
   logic        hit_count;
   logic        hit_any;
   logic        feed_first;
   logic        feed_second;
   logic        bad_acc;
   logic        tick;
   logic        underflow;
   logic        fire;
   logic [31:0] wr_merge;

   // one-cycle ack: a request is taken only while ack is low
   assign req        = cyc_i && stb_i && !s_q.ack;
   assign hit_mode   = adr_i == wtfr_pkg::ADDR_MODE;
   assign hit_reload = adr_i == wtfr_pkg::ADDR_RELOAD;
   assign hit_feed   = adr_i == wtfr_pkg::ADDR_FEED;
   assign hit_count  = adr_i == wtfr_pkg::ADDR_COUNT;
   assign hit_any    = hit_mode || hit_reload || hit_feed || hit_count;

   assign feed_first  = req && we_i && hit_feed && sel_i[0]
                        && dat_i[7:0] == wtfr_pkg::FEED_FIRST;      // [R19]
   assign feed_second = req && we_i && hit_feed && sel_i[0]
                        && dat_i[7:0] == wtfr_pkg::FEED_SECOND;     // [R19]

   // any other watchdog access while half-fed is an error, but only
   // once the dog has been started by a complete feed
   assign bad_acc = req && hit_any && !feed_second
                    && s_q.feed == wtfr_pkg::FEED_GOT_FIRST
                    && s_q.running;                            // [R5] [R6]

   assign tick      = s_q.running
                      && s_q.prescale == wtfr_pkg::PRESCALE_LAST;  // [R1]
   assign underflow = tick
                      && s_q.current_count == wtfr_pkg::COUNT_ZERO; // [R20]
   assign fire      = underflow || s_q.err_pend;

   // byte lanes merged onto the stored reload before the floor is applied
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         wr_merge[8*i +: 8] = sel_i[i] ? dat_i[8*i +: 8]
                                       : s_q.reload_constant[8*i +: 8];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb
   begin
      s_d            = s_q;
      s_d.ack        = 1'b0;
      s_d.chip_reset = 1'b0;
      s_d.err_pend   = bad_acc;                                  // [R7]

      // prescaler and counter
      if (s_q.running)
      begin
         s_d.prescale = s_q.prescale + wtfr_pkg::PRESCALE_ONE;      // [R1]
         if (tick && !underflow)
         begin
            s_d.current_count = s_q.current_count
                                - wtfr_pkg::COUNT_ONE;             // [R1]
         end
      end

      // bus access
      if (req)
      begin
         s_d.ack   = 1'b1;
         s_d.rdata = 32'h0000_0000;
         if (!we_i)
         begin
            if (hit_mode)
            begin
               s_d.rdata[wtfr_pkg::MODE_EN_BIT]  = s_q.dog_enable;   // [R14]
               s_d.rdata[wtfr_pkg::MODE_RST_BIT] = s_q.chip_reset_enable;
               s_d.rdata[wtfr_pkg::MODE_TOF_BIT] = s_q.timeout_flag;
               s_d.rdata[wtfr_pkg::MODE_IRQ_BIT] = s_q.timeout_irq_flag;
            end
            else if (hit_reload)
            begin
               s_d.rdata = s_q.reload_constant;
            end
            else if (hit_count)
            begin
               s_d.rdata = s_q.current_count;                      // [R16]
            end
         end
         else if (hit_mode && sel_i[0])
         begin
            // enable bits can only be set from software
            if (dat_i[wtfr_pkg::MODE_EN_BIT])
            begin
               s_d.dog_enable = 1'b1;                              // [R11]
            end
            if (dat_i[wtfr_pkg::MODE_RST_BIT])
            begin
               s_d.chip_reset_enable = 1'b1;                       // [R11]
            end
            if (!dat_i[wtfr_pkg::MODE_TOF_BIT])
            begin
               s_d.timeout_flag = 1'b0;                            // [R12]
            end
         end
         else if (hit_reload)
         begin
            s_d.reload_constant = wr_merge < wtfr_pkg::RELOAD_MIN
                                  ? wtfr_pkg::RELOAD_MIN
                                  : wr_merge;                      // [R2]
         end
      end

      // feed sequence
      case (s_q.feed)
         wtfr_pkg::FEED_IDLE:
         begin
            if (feed_first)
            begin
               s_d.feed = wtfr_pkg::FEED_GOT_FIRST;                // [R3]
            end
         end
         wtfr_pkg::FEED_GOT_FIRST:
         begin
            if (feed_second)
            begin
               s_d.feed          = wtfr_pkg::FEED_IDLE;
               s_d.current_count = s_q.reload_constant;        // [R3] [R15]
               s_d.prescale      = wtfr_pkg::PRESCALE_RST;
               if (s_q.dog_enable)
               begin
                  s_d.running = 1'b1;                         // [R4] [R8]
               end
            end
            else if (req && hit_any)
            begin
               // a broken pair is dropped; when running it also fires
               s_d.feed = wtfr_pkg::FEED_IDLE;                     // [R5]
            end
         end
         default:
         begin
            s_d.feed = wtfr_pkg::FEED_IDLE;
         end
      endcase

      // time-out action; running needs enable, so enable low never fires
      if (fire)
      begin
         s_d.timeout_flag      = 1'b1;                             // [R12]
         s_d.running           = 1'b0;
         s_d.dog_enable        = 1'b0;                             // [R11]
         s_d.chip_reset_enable = 1'b0;                             // [R11]
         s_d.err_pend          = 1'b0;
         s_d.feed              = wtfr_pkg::FEED_IDLE;
         s_d.prescale          = wtfr_pkg::PRESCALE_RST;
         if (s_q.chip_reset_enable)
         begin
            // the chip reset returns the block to reset values too,
            // except the time-out flag, so software can see the cause
            s_d.chip_reset       = 1'b1;                     // [R10] [R17]
            s_d.timeout_irq_flag = 1'b0;                           // [R10]
            s_d.reload_constant  = wtfr_pkg::RELOAD_RST;
            s_d.current_count    = wtfr_pkg::COUNT_RST;
         end
         else
         begin
            s_d.timeout_irq_flag = 1'b1;                           // [R9]
            s_d.current_count    = s_q.reload_constant;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_q.ack               <= 1'b0;
         s_q.rdata             <= 32'h0000_0000;
         s_q.dog_enable        <= 1'b0;
         s_q.chip_reset_enable <= 1'b0;
         s_q.timeout_flag      <= 1'b0;
         s_q.timeout_irq_flag  <= 1'b0;
         s_q.running           <= 1'b0;
         s_q.err_pend          <= 1'b0;
         s_q.chip_reset        <= 1'b0;
         s_q.prescale          <= wtfr_pkg::PRESCALE_RST;
         s_q.reload_constant   <= wtfr_pkg::RELOAD_RST;           // [R15]
         s_q.current_count     <= wtfr_pkg::COUNT_RST;            // [R16]
         s_q.feed              <= wtfr_pkg::FEED_IDLE;
      end
      else if (ce_i)
      begin
         s_q <= s_d;
      end
   end

   assign dat_o        = s_q.rdata;
   assign ack_o        = s_q.ack;
   assign irq_o        = s_q.timeout_irq_flag;                     // [R13]
   assign chip_reset_o = s_q.chip_reset;

   ////////////////////////////////////////////////////////////////////////
   // checks
   reload_floor_a: assert property ( // [R2]
      @(posedge clk_i) disable iff (rst_i)
      s_q.reload_constant >= wtfr_pkg::RELOAD_MIN)
      else $error("reload constant below minimum");

   count_step_a: assert property ( // [R1]
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && tick && !underflow && !fire && !feed_second)
      |=> s_q.current_count == $past(s_q.current_count) - 32'h0000_0001)
      else $error("counter did not step by one on tick");

   count_hold_a: assert property ( // [R1]
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && !tick && !fire && !feed_second)
      |=> s_q.current_count == $past(s_q.current_count))
      else $error("counter moved without a prescaled tick");

   feed_reload_a: assert property ( // [R3]
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && feed_second && s_q.feed == wtfr_pkg::FEED_GOT_FIRST
       && !fire)
      |=> s_q.current_count == $past(s_q.reload_constant)
          && s_q.running == $past(s_q.dog_enable))
      else $error("valid feed did not reload or start");

   idle_quiet_a: assert property ( // [R5]
      @(posedge clk_i) disable iff (rst_i)
      (!s_q.running && !s_q.err_pend)
      |=> !s_q.chip_reset && s_q.timeout_irq_flag
          == $past(s_q.timeout_irq_flag))
      else $error("action while watchdog not running");

   err_delay_a: assert property ( // [R7]
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && bad_acc) ##1 ce_i
      |=> (s_q.chip_reset || s_q.timeout_irq_flag) && s_q.timeout_flag)
      else $error("bad feed access did not fire in time");

   enable_sticky_a: assert property ( // [R11]
      @(posedge clk_i) disable iff (rst_i)
      (s_q.dog_enable && !(ce_i && fire)) |=> s_q.dog_enable)
      else $error("enable bit cleared without time-out");

   irq_hold_a: assert property ( // [R13]
      @(posedge clk_i) disable iff (rst_i)
      (s_q.timeout_irq_flag
       && !(ce_i && fire && s_q.chip_reset_enable))
      |=> s_q.timeout_irq_flag)
      else $error("interrupt request dropped before reset");

   mode_reset_a: assert property ( // [R10]
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && fire && s_q.chip_reset_enable)
      |=> s_q.chip_reset && !s_q.timeout_irq_flag && s_q.timeout_flag)
      else $error("reset mode time-out handled wrongly");

   mode_irq_a: assert property ( // [R9]
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && fire && !s_q.chip_reset_enable)
      |=> !s_q.chip_reset && s_q.timeout_irq_flag)
      else $error("interrupt mode time-out handled wrongly");

   pulse_once_a: assert property ( // [R20]
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && s_q.chip_reset) |=> !s_q.chip_reset)
      else $error("chip reset request longer than one cycle");

   ack_once_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && s_q.ack) |=> !s_q.ack)
      else $error("ack held for more than one cycle");

   enable_gate_a: assert property ( // [R8]
      @(posedge clk_i) disable iff (rst_i)
      !s_q.dog_enable |-> !s_q.running)
      else $error("watchdog running while disabled");

   rst_en_sticky_a: assert property ( // [R11]
      @(posedge clk_i) disable iff (rst_i)
      (s_q.chip_reset_enable && !(ce_i && fire)) |=> s_q.chip_reset_enable)
      else $error("reset enable cleared without time-out");

   tof_sticky_a: assert property ( // [R12]
      @(posedge clk_i) disable iff (rst_i)
      (s_q.timeout_flag && !(ce_i && req && we_i && hit_mode && sel_i[0]
                             && !dat_i[wtfr_pkg::MODE_TOF_BIT]))
      |=> s_q.timeout_flag)
      else $error("time-out flag lost without software clear");

   tof_set_a: assert property ( // [R12]
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && fire) |=> s_q.timeout_flag)
      else $error("time-out flag not set on time-out");

   count_read_a: assert property ( // [R16]
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && req && !we_i && hit_count)
      |=> s_q.rdata == $past(s_q.current_count))
      else $error("count read returned wrong value");

   reload_write_a: assert property ( // [R2]
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && req && we_i && hit_reload && sel_i == 4'hF && !fire)
      |=> s_q.reload_constant == ($past(dat_i) < wtfr_pkg::RELOAD_MIN
                                  ? wtfr_pkg::RELOAD_MIN : $past(dat_i)))
      else $error("reload write not floored at minimum");

   reset_only_a: assert property ( // [R10]
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && !(fire && s_q.chip_reset_enable)) |=> !s_q.chip_reset)
      else $error("chip reset request outside reset mode time-out");

   irq_only_a: assert property ( // [R9]
      @(posedge clk_i) disable iff (rst_i)
      (!s_q.timeout_irq_flag && !(ce_i && fire && !s_q.chip_reset_enable))
      |=> !s_q.timeout_irq_flag)
      else $error("interrupt flag set outside interrupt mode time-out");

   prescale_step_a: assert property ( // [R1]
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && s_q.running && !fire
       && !(feed_second && s_q.feed == wtfr_pkg::FEED_GOT_FIRST))
      |=> s_q.prescale == $past(s_q.prescale) + wtfr_pkg::PRESCALE_ONE)
      else $error("prescaler did not advance while running");

endmodule : wtfr_top

// ---- testbench/wtfr_sys_model.sv ----
// Purpose: system side model, reset controller and program counter
// Assumes: chip_reset_i is a one-cycle request on clk_i
// Notes:   counts reset requests and keeps the time of the last one
`timescale 1ns/1ps

module wtfr_sys_model
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        chip_reset_i,
   output logic      [7:0]  resets_o,
   output time              reset_at_o,
   output logic      [31:0] pc_o
);
   ////////////////////////////////////////////////////////////////////////
   // program restarts at zero after either reset source
   always_ff @(posedge clk_i)
   begin
      if (rst_i || chip_reset_i)
         pc_o <= 32'h0000_0000;
      else
         pc_o <= pc_o + 32'h0000_0004;
      if (rst_i)
         resets_o <= 8'h00;
      else if (chip_reset_i)
         resets_o <= resets_o + 8'h01;
      if (chip_reset_i)
         reset_at_o <= $time;
   end
endmodule : wtfr_sys_model

// ---- testbench/wtfr_top_tb_top.sv ----
// Purpose: register level test of the watchdog over Wishbone
// Assumes: ce_i held high, all byte lanes enabled
// Notes:   the reset request is not looped back, so timeout flag stays
`timescale 1ns/1ps

module wtfr_top_tb_top;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i  = 1'b0;
   logic [31:0] adr_i = 32'h0000_0000;
   logic [31:0] dat_i = 32'h0000_0000;
   logic [31:0] dat_o;
   logic        ack_o;
   logic        irq_o;
   logic        chip_reset_o;
   logic [7:0]  resets;
   logic [31:0] pc;
   logic [31:0] q;
   logic [31:0] a;
   time         reset_at;
   time         t_ack;
   time         t_f;
   int          failures  = 0;
   int          tests_run = 0;
   int          k;

   always #12.5 clk_i = ~clk_i;

   wtfr_top i_wtfr_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .irq_o(irq_o), .chip_reset_o(chip_reset_o));

   wtfr_sys_model i_wtfr_sys_model (.clk_i(clk_i), .rst_i(rst_i),
      .chip_reset_i(chip_reset_o), .resets_o(resets),
      .reset_at_o(reset_at), .pc_o(pc));

   ////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("%0d mismatches in %0d checks", failures, tests_run);
      if (failures == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one classic cycle; a dead slave ends the run instead of hanging
   task automatic bus(input logic w, input logic [31:0] ad,
                      input logic [31:0] d);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= ad;
      dat_i <= d;
      @(posedge clk_i);
      while (ack_o !== 1'b1 && n < 40)
      begin
         @(posedge clk_i);
         n++;
      end
      q = dat_o;
      t_ack = $time;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (n >= 40)
      begin
         failures++;
         summarize();
      end
      @(posedge clk_i);
   endtask : bus

   task automatic rc(input logic [31:0] ad, input logic [31:0] exp);
      bus(1'b0, ad, 32'h0000_0000);
      chk(q, exp);
   endtask : rc

   // both writes back to back, nothing else on the bus in between
   task automatic feed();
      bus(1'b1, wtfr_pkg::ADDR_FEED, 32'(wtfr_pkg::FEED_FIRST));
      bus(1'b1, wtfr_pkg::ADDR_FEED, 32'(wtfr_pkg::FEED_SECOND));
      t_f = t_ack;
   endtask : feed

   task automatic wait_resets(input logic [7:0] n);
      k = 0;
      while (resets !== n && k < 1200)
      begin
         @(posedge clk_i);
         k++;
      end
      if (resets !== n)
      begin
         failures++;
         summarize();
      end
   endtask : wait_resets

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rc(wtfr_pkg::ADDR_MODE, 32'h0000_0000);
      rc(wtfr_pkg::ADDR_RELOAD, 32'h0000_00FF);
      bus(1'b1, wtfr_pkg::ADDR_COUNT, 32'h0000_1234);
      rc(wtfr_pkg::ADDR_COUNT, 32'h0000_00FF);
      rc(wtfr_pkg::ADDR_FEED, 32'h0000_0000);
      rc(32'hE000_0010, 32'h0000_0000);
      bus(1'b1, wtfr_pkg::ADDR_RELOAD, 32'h0000_00FE);
      rc(wtfr_pkg::ADDR_RELOAD, 32'h0000_00FF);
      bus(1'b1, wtfr_pkg::ADDR_RELOAD, 32'h0000_0104);
      rc(wtfr_pkg::ADDR_RELOAD, 32'h0000_0104);
      $display("register test done");
      bus(1'b1, wtfr_pkg::ADDR_MODE, 32'h0000_0001);
      feed();
      bus(1'b0, wtfr_pkg::ADDR_COUNT, 32'h0000_0000);
      a = q;
      chk(32'(a <= 32'h104 && a > 32'h100), 32'h1);
      // taken edges 40 cycles apart: exactly ten ticks at any phase
      repeat (37) @(posedge clk_i);
      bus(1'b0, wtfr_pkg::ADDR_COUNT, 32'h0000_0000);
      chk(a - q, 32'h0000_000A);
      bus(1'b1, wtfr_pkg::ADDR_MODE, 32'h0000_0000);
      rc(wtfr_pkg::ADDR_MODE, 32'h0000_0001);
      k = 0;
      while (irq_o !== 1'b1 && k < 1200)
      begin
         @(posedge clk_i);
         k++;
      end
      if (irq_o !== 1'b1)
      begin
         failures++;
         summarize();
      end
      k = int'(($time - t_f) / 25);
      chk(32'(k > 1038 && k < 1050), 32'h1);
      rc(wtfr_pkg::ADDR_MODE, 32'h0000_000C);
      bus(1'b1, wtfr_pkg::ADDR_MODE, 32'h0000_0000);
      rc(wtfr_pkg::ADDR_MODE, 32'h0000_0008);
      chk({31'h0, irq_o}, 32'h1);
      chk(32'(resets), 32'h0);
      $display("interrupt mode test done");
      rst_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk({31'h0, irq_o}, 32'h0);
      bus(1'b1, wtfr_pkg::ADDR_MODE, 32'h0000_0002);
      rc(wtfr_pkg::ADDR_MODE, 32'h0000_0002);
      feed();
      repeat (1100) @(posedge clk_i);
      chk({23'h0, resets, irq_o}, 32'h0);
      $display("disabled test done");
      bus(1'b1, wtfr_pkg::ADDR_MODE, 32'h0000_0001);
      bus(1'b1, wtfr_pkg::ADDR_FEED, 32'h0000_00AA);
      rc(wtfr_pkg::ADDR_MODE, 32'h0000_0003);
      repeat (8) @(posedge clk_i);
      chk({23'h0, resets, irq_o}, 32'h0);
      rc(wtfr_pkg::ADDR_COUNT, 32'h0000_00FF);
      feed();
      bus(1'b1, wtfr_pkg::ADDR_FEED, 32'h0000_00AA);
      bus(1'b0, wtfr_pkg::ADDR_RELOAD, 32'h0000_0000);
      t_f = t_ack;
      repeat (4) @(posedge clk_i);
      chk(32'(resets), 32'h1);
      chk(32'(reset_at - t_f), 32'h19);
      chk(pc, 32'h0000_000C);
      bus(1'b0, wtfr_pkg::ADDR_MODE, 32'h0000_0000);
      chk(q & 32'hB, 32'h0);
      $display("feed error test done");
      bus(1'b1, wtfr_pkg::ADDR_MODE, 32'h0000_0003);
      feed();
      wait_resets(8'h02);
      chk(32'(resets), 32'h2);
      rc(wtfr_pkg::ADDR_MODE, 32'h0000_0004);
      chk({31'h0, irq_o}, 32'h0);
      $display("reset mode test done");
      summarize();
   end
endmodule : wtfr_top_tb_top
